/* pkg/misc_control_pkg.sv */
// Package: register map, field layout and decoded limits of misc_control
package misc_control_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_MISC_CONTROL = 8'h72;
  localparam logic [15:0] RESET_MISC_CONTROL = 16'h0000;
  localparam logic [15:0] WRITABLE_MASK = 16'h00fb;
  localparam int POS_READ_THR = 6;
  localparam int POS_WRITE_THR = 4;
  localparam int POS_LOCK = 3;
  localparam int POS_LOOKAHEAD = 1;
  localparam int POS_WIN_SEL = 0;
  localparam int BW_W = 10;
  localparam logic [9:0] READ_BW_00 = 10'h320;
  localparam logic [9:0] READ_BW_01 = 10'h2bc;
  localparam logic [9:0] READ_BW_10 = 10'h258;
  localparam logic [9:0] READ_BW_11 = 10'h1f4;
  localparam logic [9:0] WRITE_BW_00 = 10'h320;
  localparam logic [9:0] WRITE_BW_01 = 10'h1f4;
  localparam logic [9:0] WRITE_BW_10 = 10'h190;
  localparam logic [9:0] WRITE_BW_11 = 10'h12c;
  localparam logic [6:0] GTT_SIZE_64 = 7'h40;
  localparam logic [6:0] GTT_SIZE_32 = 7'h20;

  typedef struct packed {
    logic [9:0] read_limit_mbps;
    logic read_limited;
    logic [9:0] write_limit_mbps;
    logic write_limited;
    logic lookahead_en;
    logic [6:0] gtt_size_mb;
  } misc_ctl_t;
endpackage : misc_control_pkg

/* core/misc_control_throttle_register.sv */
// Misc control register: throttle limits, lock, lookahead and table size
// Summary of operation
// - Read throttle code 00/01/10/11 gives no cap, 700, 600, 500 MB/s.
// - Write throttle code 00/01/10/11 gives no cap, 500, 400, 300 MB/s.
// - Lock bit 3 is set by a write of one and stays set until reset.
// - While locked, writes to bits 7 to 3 are ignored.
// - After reset the register reads all zeros.
// - Bit 1 enables lookahead for the block new requests decision.
// - In internal graphics mode bit 0 selects a 64 MB or 32 MB table.
// - Aperture control bit 0 low is port mode, high internal graphics.
module misc_control_throttle_register
  import misc_control_pkg::*;
(
  input wire logic clk_sys, // 200 MHz clock
  input wire logic rstn, // Async reset, active low
  input wire logic clk_en, // Freezes all state when low
  input wire logic [ADDR_W-1:0] addr, // Byte address
  input wire logic [15:0] wdata, // Write data
  input wire logic wr_en, // Write strobe
  input wire logic rd_en, // Read strobe
  output logic [15:0] rdata, // Read data, cycle after strobe
  input wire logic aperture_gfx_mode, // Aperture control bit 0
  output misc_ctl_t ctl // Decoded controls
);

  logic [15:0] misc_control;
  logic locked;
  logic hit;
  misc_ctl_t next_ctl;

  assign hit = (addr == OFF_MISC_CONTROL);
  assign locked = misc_control[POS_LOCK];

  // ****************************************
  // Register write
  // ****************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      misc_control <= RESET_MISC_CONTROL;
    end else if (clk_en && wr_en && hit) begin
      if (locked) begin
        misc_control[1:0] <= wdata[1:0];
      end else begin
        misc_control <= wdata & WRITABLE_MASK;
      end
    end
  end

  // ****************************************
  // Register read
  // ****************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata <= 16'h0000;
    end else if (clk_en) begin
      if (rd_en && hit) begin
        rdata <= misc_control;
      end else begin
        rdata <= 16'h0000;
      end
    end
  end

  // ****************************************
  // Decode of controls
  // ****************************************
  always_comb begin
    next_ctl = '0;
    case (misc_control[POS_READ_THR +: 2])
      2'h0: next_ctl.read_limit_mbps = READ_BW_00;
      2'h1: next_ctl.read_limit_mbps = READ_BW_01;
      2'h2: next_ctl.read_limit_mbps = READ_BW_10;
      default: next_ctl.read_limit_mbps = READ_BW_11;
    endcase
    next_ctl.read_limited = (misc_control[POS_READ_THR +: 2] != 2'h0);
    case (misc_control[POS_WRITE_THR +: 2])
      2'h0: next_ctl.write_limit_mbps = WRITE_BW_00;
      2'h1: next_ctl.write_limit_mbps = WRITE_BW_01;
      2'h2: next_ctl.write_limit_mbps = WRITE_BW_10;
      default: next_ctl.write_limit_mbps = WRITE_BW_11;
    endcase
    next_ctl.write_limited = (misc_control[POS_WRITE_THR +: 2] != 2'h0);
    next_ctl.lookahead_en = misc_control[POS_LOOKAHEAD];
    if (aperture_gfx_mode) begin
      next_ctl.gtt_size_mb = misc_control[POS_WIN_SEL] ? GTT_SIZE_32
                                                       : GTT_SIZE_64;
    end else begin
      next_ctl.gtt_size_mb = 7'h00;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctl <= '0;
    end else if (clk_en) begin
      ctl <= next_ctl;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_lock_sticky: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    locked |=> locked)
    else $error("lock bit cleared without reset");

  a_lock_freezes: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    locked |=> $stable(misc_control[7:3]))
    else $error("locked field changed");

  a_reserved_zero: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    misc_control[15:8] == 8'h00 && !misc_control[2])
    else $error("reserved bit set");

  a_write_takes: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    clk_en && wr_en && hit && !locked |=>
      misc_control == ($past(wdata) & WRITABLE_MASK))
    else $error("unlocked write not stored");

  a_read_limit: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    clk_en && misc_control[7:6] == 2'h3 |=> ctl.read_limit_mbps == 10'h1f4)
    else $error("read limit wrong");

  a_write_limit: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    clk_en && misc_control[5:4] == 2'h2 |=> ctl.write_limit_mbps == 10'h190)
    else $error("write limit wrong");

  a_lookahead_out: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    clk_en |=> ctl.lookahead_en == $past(misc_control[1]))
    else $error("lookahead not forwarded");

  a_gtt_size: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    clk_en && aperture_gfx_mode && misc_control[0] |=>
      ctl.gtt_size_mb == 7'h20)
    else $error("table size wrong");

  a_read_data: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    clk_en && rd_en && hit |=> rdata[15:8] == 8'h00 && !rdata[2])
    else $error("read shows reserved bits");

  // ****************************************
  // Checks of read codes 00/01/10 and write codes 00/01/11
  // ****************************************
  a_read_free: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    clk_en && misc_control[POS_READ_THR +: 2] == 2'h0 |=>
      ctl.read_limit_mbps == READ_BW_00 && !ctl.read_limited)
    else $error("read code zero gives a limit");

  a_read_mid: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    clk_en && misc_control[POS_READ_THR +: 2] == 2'h1 |=>
      ctl.read_limit_mbps == READ_BW_01 && ctl.read_limited)
    else $error("read code one limit wrong");

  a_read_low: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    clk_en && misc_control[POS_READ_THR +: 2] == 2'h2 |=>
      ctl.read_limit_mbps == READ_BW_10 && ctl.read_limited)
    else $error("read code two limit wrong");

  a_write_free: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    clk_en && misc_control[POS_WRITE_THR +: 2] == 2'h0 |=>
      ctl.write_limit_mbps == WRITE_BW_00 && !ctl.write_limited)
    else $error("write code zero gives a limit");

  a_write_high: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    clk_en && misc_control[POS_WRITE_THR +: 2] == 2'h1 |=>
      ctl.write_limit_mbps == WRITE_BW_01 && ctl.write_limited)
    else $error("write code one limit wrong");

  a_write_low: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    clk_en && misc_control[POS_WRITE_THR +: 2] == 2'h3 |=>
      ctl.write_limit_mbps == WRITE_BW_11 && ctl.write_limited)
    else $error("write code three limit wrong");

  // ****************************************
  // Checks of lock, table size and read port
  // ****************************************
  a_lock_sets: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    clk_en && wr_en && hit && wdata[POS_LOCK] |=>
      misc_control[POS_LOCK])
    else $error("lock write not taken");

  a_lock_blocks: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    clk_en && wr_en && hit && locked |=>
      misc_control[7:3] == $past(misc_control[7:3]))
    else $error("locked write reached bits 7 to 3");

  a_locked_low_bits: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    clk_en && wr_en && hit && locked |=>
      misc_control[1:0] == $past(wdata[1:0]))
    else $error("low bits not written while locked");

  a_gtt_default: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    clk_en && aperture_gfx_mode && !misc_control[POS_WIN_SEL] |=>
      ctl.gtt_size_mb == GTT_SIZE_64)
    else $error("default table size wrong");

  a_port_mode: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    clk_en && !aperture_gfx_mode |=> ctl.gtt_size_mb == 7'h00)
    else $error("table size shown in port mode");

  a_read_shows: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    clk_en && rd_en && hit |=> rdata == $past(misc_control))
    else $error("read data differ from register");

  a_read_idle: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    clk_en && !(rd_en && hit) |=> rdata == 16'h0000)
    else $error("read data without a read hit");

  a_reset_clear: assert property (
    @(posedge clk_sys)
    !rstn |=> misc_control == RESET_MISC_CONTROL && ctl == '0)
    else $error("state not cleared by reset");

endmodule : misc_control_throttle_register

/* tb/misc_control_throttle_register_bench.sv */
// Self-checking bench for the misc control throttle register
`define CHK(a, b) chk(32'(a), 32'(b))
module misc_control_throttle_register_bench import misc_control_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 0, rstn = 0, clk_en = 1, wr_en = 0, rd_en = 0, internal_graphics_mode = 0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000, rdata, m = 16'h0000, s = 16'h2d74;
  misc_ctl_t ctl;
  int n_errors = 0, cmp_count = 0;
  misc_control_throttle_register i_dut (.clk_sys(clk_sys), .rstn(rstn),
    .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .aperture_gfx_mode(internal_graphics_mode), .ctl(ctl));
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr
  function automatic misc_ctl_t decode(input logic [15:0] r, input logic g);
    decode.read_limit_mbps = 10'(10'h320 - 10'h064 * r[7:6]);
    decode.read_limited = r[7:6] != 2'h0;
    decode.write_limit_mbps = (r[5:4] == 2'h0) ? 10'h320 :
      10'(10'h258 - 10'h064 * r[5:4]);
    decode.write_limited = r[5:4] != 2'h0;
    decode.lookahead_en = r[1];
    decode.gtt_size_mb = !g ? 7'h00 : (r[0] ? 7'h20 : 7'h40);
  endfunction : decode
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    // Locked register only lets bits 1:0 through
    if (a == 8'h72) begin
      m = (m & ~(m[3] ? 16'h0003 : 16'h00fb)) | (d & (m[3] ? 16'h0003 : 16'h00fb));
    end
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    `CHK(rdata, (a == 8'h72) ? m : 16'h0000);
    `CHK(ctl, decode(m, internal_graphics_mode));
  endtask : rd
  task automatic final_report;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report
  // ****************
  // Stimulus
  // ****************
  initial begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(8'h72);
    for (int i = 0; i < 80; i++) begin
      s = lfsr(s);
      @(posedge clk_sys);
      internal_graphics_mode <= s[9];
      if (i == 40) begin
        wr(8'h72, 16'hff5a);
      end
      wr(i[1:0] == 2'h3 ? s[15:8] : 8'h72, i < 40 ? s & 16'hfff7 : s);
      rd(i[2:0] == 3'h5 ? 8'h73 : 8'h72);
    end
    // Write with the clock enable low must not land
    @(posedge clk_sys);
    clk_en <= 1'b0;
    wr_en <= 1'b1;
    addr <= 8'h72;
    wdata <= {14'h0000, ~m[1:0]};
    @(posedge clk_sys);
    wr_en <= 1'b0;
    @(posedge clk_sys);
    clk_en <= 1'b1;
    rd(8'h72);
    @(posedge clk_sys);
    rstn <= 1'b0;
    m = 16'h0000;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(8'h72);
    wr(8'h72, 16'h00b4);
    rd(8'h72);
    final_report();
  end
  initial begin
    repeat (3000) @(posedge clk_sys);
    n_errors++;
    final_report();
  end
endmodule : misc_control_throttle_register_bench
